/* rtl/attr_entry_store.sv */
// Byte-writable storage for the attribute entries, registered read port
`timescale 1ns/1ps
`default_nettype none
module attr_entry_store #(
    parameter int unsigned WORDS = 4,
    parameter int unsigned WIDTH = 64
) (
    input  wire logic                     clk_i,
    input  wire logic                     wr_en_i,
    input  wire logic [WIDTH/8-1:0]       byte_en_i,
    input  wire logic [$clog2(WORDS)-1:0] addr_i,
    input  wire logic [WIDTH-1:0]         wdata_i,
    output logic      [WIDTH-1:0]         rdata_o,
    output logic      [WORDS*WIDTH-1:0]   words_o
);
    logic [WIDTH-1:0] mem_q [WORDS];

    // Entries carry no reset value
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            for (int b = 0; b < WIDTH / 8; b++) begin
                if (byte_en_i[b]) begin
                    mem_q[addr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
                end
            end
        end
    end

    // Old contents on a same-cycle write
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_q[addr_i];
    end

    always_comb begin
        for (int w = 0; w < WORDS; w++) begin
            words_o[w*WIDTH +: WIDTH] = mem_q[w];
        end
    end
endmodule : attr_entry_store
`default_nettype wire

/* rtl/mem_attr_cfg_csrs.sv */
// Upper attribute configuration CSR bank, entries 32 to 63
// How it works
// - Even CSRs 64 bits in RV64, else 32
// - Odd CSRs exist only in RV32 format
// - 0x7EA holds entries 40 to 47
// - RV32 0x7EB holds entries 44 to 47
// - 0x7EC holds entries 48 to 55
// - RV32 0x7ED holds entries 52 to 55
// - 0x7EE holds entries 56 to 63
// - RV32 0x7EF holds entries 60 to 63
// - Entries read/write, no reset value
// - 0x7E8 holds entries 32 to 39
`timescale 1ns/1ps
`default_nettype none
module mem_attr_cfg_csrs #(
    parameter int unsigned WORDS = mem_attr_cfg_pkg::GROUP_WORDS
) (
    input  wire logic         CLOCK_I,
    input  wire logic         NRST_I,
    input  wire logic         CSR_XLEN64_I,
    input  wire logic         CSR_VALID_I,
    input  wire logic         CSR_WE_I,
    input  wire logic [11:0]  CSR_ADDR_I,
    input  wire logic [63:0]  CSR_WDATA_I,
    output logic              CSR_RVALID_O,
    output logic              CSR_ERROR_O,
    output logic      [63:0]  CSR_RDATA_O,
    output logic      [255:0] ATTR_ENTRIES_O
);
    // Address decode for both formats
    function automatic mem_attr_cfg_pkg::csr_decode_t decode(
        input logic [11:0] addr,
        input logic        rv64
    );
        mem_attr_cfg_pkg::csr_decode_t d;
        d.hit   = (addr[11:3] == mem_attr_cfg_pkg::CFG_GROUP8_ADDR[11:3]) && !(rv64 && addr[0]);
        d.word  = addr[2:1];
        d.upper = !rv64 && addr[0];
        return d;
    endfunction : decode

    mem_attr_cfg_pkg::csr_decode_t dec;
    logic                          wr_en;
    logic [7:0]                    byte_en;
    logic [63:0]                   wr_data;
    logic [63:0]                   mem_rdata;
    logic [255:0]                  entries;

    logic                          s1_valid_q;
    logic                          s1_hit_q;
    logic                          s1_upper_q;
    logic                          s1_rv64_q;
    logic                          rvalid_q;
    logic                          error_q;
    logic [63:0]                   rdata_q;

    always_comb begin
        dec = decode(CSR_ADDR_I, CSR_XLEN64_I);
    end

    assign wr_en = CSR_VALID_I && CSR_WE_I && dec.hit && NRST_I;

    always_comb begin
        if (CSR_XLEN64_I) begin
            byte_en = mem_attr_cfg_pkg::BE_FULL;
        end else if (dec.upper) begin
            byte_en = mem_attr_cfg_pkg::BE_UPPER;
        end else begin
            byte_en = mem_attr_cfg_pkg::BE_LOWER;
        end
    end

    always_comb begin
        if (dec.upper) begin
            wr_data = {CSR_WDATA_I[31:0], CSR_WDATA_I[31:0]};
        end else begin
            wr_data = CSR_WDATA_I;
        end
    end

    attr_entry_store #(
        .WORDS (WORDS),
        .WIDTH (mem_attr_cfg_pkg::DATA_W)
    ) u_store (
        .clk_i     (CLOCK_I),
        .wr_en_i   (wr_en),
        .byte_en_i (byte_en),
        .addr_i    (dec.word),
        .wdata_i   (wr_data),
        .rdata_o   (mem_rdata),
        .words_o   (entries)
    );

    // Request stage
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            s1_valid_q <= 1'h0;
            s1_hit_q   <= 1'h0;
            s1_upper_q <= 1'h0;
            s1_rv64_q  <= 1'h0;
        end else begin
            s1_valid_q <= CSR_VALID_I;
            s1_hit_q   <= dec.hit;
            s1_upper_q <= dec.upper;
            s1_rv64_q  <= CSR_XLEN64_I;
        end
    end

    // Answer handshake
    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            rvalid_q <= 1'h0;
            error_q  <= 1'h0;
        end else begin
            rvalid_q <= s1_valid_q;
            error_q  <= s1_valid_q && !s1_hit_q;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            rdata_q <= {64{mem_attr_cfg_pkg::RDATA_RST}};
        end else if (!s1_valid_q || !s1_hit_q) begin
            rdata_q <= 64'h0;
        end else if (s1_rv64_q) begin
            rdata_q <= mem_rdata;
        end else if (s1_upper_q) begin
            rdata_q <= {32'h0, mem_rdata[63:32]};
        end else begin
            rdata_q <= {32'h0, mem_rdata[31:0]};
        end
    end

    assign CSR_RVALID_O   = rvalid_q;
    assign CSR_ERROR_O    = error_q;
    assign CSR_RDATA_O    = rdata_q;
    assign ATTR_ENTRIES_O = entries;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);

    rv32_width_a: assert property (
        CSR_RVALID_O && !$past(s1_rv64_q) |-> CSR_RDATA_O[63:32] == 32'h0
    ) else $error("RV32 read has upper bits set");

    odd_rv64_a: assert property (
        CSR_VALID_I && CSR_XLEN64_I && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP11_ADDR
        |-> ##2 CSR_ERROR_O && CSR_RVALID_O && CSR_RDATA_O == 64'h0
    ) else $error("Odd CSR accepted in RV64");

    grp10_layout_a: assert property (
        CSR_VALID_I && CSR_WE_I && CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP10_ADDR
        |=> ATTR_ENTRIES_O[71:64] == $past(CSR_WDATA_I[7:0])
            && ATTR_ENTRIES_O[127:120] == $past(CSR_WDATA_I[63:56])
    ) else $error("Entries 40 or 47 misplaced");

    grp11_layout_a: assert property (
        CSR_VALID_I && CSR_WE_I && !CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP11_ADDR
        |=> ATTR_ENTRIES_O[103:96] == $past(CSR_WDATA_I[7:0])
            && ATTR_ENTRIES_O[127:120] == $past(CSR_WDATA_I[31:24])
    ) else $error("Entries 44 or 47 misplaced");

    grp12_layout_a: assert property (
        CSR_VALID_I && CSR_WE_I && CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP12_ADDR
        |=> ATTR_ENTRIES_O[167:160] == $past(CSR_WDATA_I[39:32])
    ) else $error("Entry 52 misplaced");

    grp13_layout_a: assert property (
        CSR_VALID_I && CSR_WE_I && !CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP13_ADDR
        |=> ATTR_ENTRIES_O[167:160] == $past(CSR_WDATA_I[7:0])
            && $stable(ATTR_ENTRIES_O[159:128])
    ) else $error("Entry 52 misplaced in RV32");

    grp14_layout_a: assert property (
        CSR_VALID_I && CSR_WE_I && CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP14_ADDR
        |=> ATTR_ENTRIES_O[223:216] == $past(CSR_WDATA_I[31:24])
            && ATTR_ENTRIES_O[255:248] == $past(CSR_WDATA_I[63:56])
    ) else $error("Entry 59 or 63 misplaced");

    grp15_layout_a: assert property (
        CSR_VALID_I && CSR_WE_I && !CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP15_ADDR
        |=> ATTR_ENTRIES_O[231:224] == $past(CSR_WDATA_I[7:0])
            && ATTR_ENTRIES_O[255:248] == $past(CSR_WDATA_I[31:24])
    ) else $error("Entry 60 or 63 misplaced");

    rv32_readback_a: assert property (
        CSR_VALID_I && !CSR_WE_I && !CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP11_ADDR
        |-> ##2 CSR_RVALID_O && CSR_RDATA_O[31:0] == $past(ATTR_ENTRIES_O[127:96], 2)
    ) else $error("RV32 odd read wrong");

    grp8_layout_a: assert property (
        CSR_VALID_I && CSR_WE_I && CSR_XLEN64_I
            && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP8_ADDR
        |=> ATTR_ENTRIES_O[7:0] == $past(CSR_WDATA_I[7:0])
    ) else $error("Entry 32 misplaced");

    shared_view_a: assert property (
        CSR_VALID_I && CSR_XLEN64_I && CSR_ADDR_I == mem_attr_cfg_pkg::CFG_GROUP10_ADDR
        |-> ##2 CSR_RVALID_O && !CSR_ERROR_O
            && CSR_RDATA_O == $past(ATTR_ENTRIES_O[127:64], 2)
    ) else $error("RV64 view differs from storage");

    entry_hold_a: assert property (
        !(CSR_VALID_I && CSR_WE_I) |=> $stable(ATTR_ENTRIES_O)
    ) else $error("Entries changed without a write");
endmodule : mem_attr_cfg_csrs
`default_nettype wire

/* rtl/mem_attr_cfg_pkg.sv */
// Constants for the upper attribute configuration CSR bank
package mem_attr_cfg_pkg;
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned DATA_W       = 64;
    localparam int unsigned HALF_W       = 32;
    localparam int unsigned ENTRY_W      = 8;
    localparam int unsigned ENTRY_FIRST  = 32;
    localparam int unsigned ENTRY_COUNT  = 32;
    localparam int unsigned GROUP_WORDS  = 4;
    localparam int unsigned BYTES_PER_WD = 8;
    localparam int unsigned READ_LATENCY = 2;

    localparam logic [11:0] CFG_GROUP8_ADDR  = 12'h7e8;
    localparam logic [11:0] CFG_GROUP9_ADDR  = 12'h7e9;
    localparam logic [11:0] CFG_GROUP10_ADDR = 12'h7ea;
    localparam logic [11:0] CFG_GROUP11_ADDR = 12'h7eb;
    localparam logic [11:0] CFG_GROUP12_ADDR = 12'h7ec;
    localparam logic [11:0] CFG_GROUP13_ADDR = 12'h7ed;
    localparam logic [11:0] CFG_GROUP14_ADDR = 12'h7ee;
    localparam logic [11:0] CFG_GROUP15_ADDR = 12'h7ef;

    localparam logic [7:0]  BE_FULL  = 8'hff;
    localparam logic [7:0]  BE_LOWER = 8'h0f;
    localparam logic [7:0]  BE_UPPER = 8'hf0;

    localparam logic        RDATA_RST = 1'h0;

    typedef struct packed {
        logic       hit;
        logic [1:0] word;
        logic       upper;
    } csr_decode_t;
endpackage : mem_attr_cfg_pkg

/* test/phys_mem_attr_cfg_csrs_hi_test.sv */
// Self-checking bench for the upper attribute configuration CSR bank
`timescale 1ns/1ps
`default_nettype none
module phys_mem_attr_cfg_csrs_hi_test;
    logic         clk;
    logic         nrst;
    logic         x64;
    logic         valid;
    logic         we;
    logic [11:0]  addr;
    logic [63:0]  wdata;
    logic         rvalid;
    logic         error;
    logic [63:0]  rdata;
    logic [255:0] entries;
    logic [7:0]   mdl [32];
    logic         known;
    int           mismatches;
    int           total_checks;

    mem_attr_cfg_csrs dut (
        .CLOCK_I(clk), .NRST_I(nrst), .CSR_XLEN64_I(x64), .CSR_VALID_I(valid),
        .CSR_WE_I(we), .CSR_ADDR_I(addr), .CSR_WDATA_I(wdata), .CSR_RVALID_O(rvalid),
        .CSR_ERROR_O(error), .CSR_RDATA_O(rdata), .ATTR_ENTRIES_O(entries)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic hit(input logic [11:0] a, input logic f64);
        return a >= 12'h7e8 && a <= 12'h7ef && !(f64 && a[0]);
    endfunction : hit

    function automatic logic [63:0] exp_rd(input logic [11:0] a, input logic f64);
        logic [63:0] r;
        r = 64'h0;
        if (hit(a, f64)) begin
            for (int i = 0; i < (f64 ? 8 : 4); i++) r[i*8+:8] = mdl[int'(a - 12'h7e8) * 4 + i];
        end
        return r;
    endfunction : exp_rd

    function automatic logic [255:0] exp_ent();
        logic [255:0] r;
        for (int i = 0; i < 32; i++) r[i*8+:8] = mdl[i];
        return r;
    endfunction : exp_ent

    task automatic access(input logic f64, input logic w, input logic [11:0] a,
                          input logic [63:0] d);
        logic [63:0] old;
        int          n;
        old = exp_rd(a, f64);
        x64 = f64;
        valid = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        valid = 1'b0;
        if (w && hit(a, f64)) begin
            for (int i = 0; i < (f64 ? 8 : 4); i++) mdl[int'(a - 12'h7e8) * 4 + i] = d[i*8+:8];
        end
        n = 1;
        while (rvalid !== 1'b1 && n < 5) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 5) begin
            mismatches++;
            $display("mismatch answer expected 1 seen 0");
            final_report();
        end
        chk("latency", 256'(mem_attr_cfg_pkg::READ_LATENCY), 256'(n));
        chk("error", 256'(!hit(a, f64)), 256'(error));
        if (known) chk("rdata", 256'(old), 256'(rdata));
        if (known) chk("entries", exp_ent(), entries);
        @(posedge clk);
        #1;
        chk("rvalid drop", 256'(0), 256'(rvalid));
    endtask : access

    task automatic ent(input int n, input logic [7:0] v);
        chk("entry", 256'(v), 256'(entries[(n-32)*8+:8]));
    endtask : ent

    initial begin
        nrst = 1'b0;
        x64 = 1'b0;
        valid = 1'b0;
        we = 1'b0;
        addr = 12'h0;
        wdata = 64'h0;
        known = 1'b0;
        mismatches = 0;
        total_checks = 0;
        void'($urandom(32'hb51d));
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        // program before use, back to back
        x64 = 1'b0;
        we = 1'b1;
        valid = 1'b1;
        for (int g = 0; g < 8; g++) begin
            addr = 12'h7e8 + 12'(g);
            wdata = {$urandom, $urandom};
            for (int i = 0; i < 4; i++) mdl[g * 4 + i] = wdata[i*8+:8];
            @(posedge clk);
            #1;
            chk("burst rvalid", 256'(g != 0), 256'(rvalid));
            chk("burst error", 256'(0), 256'(error));
        end
        valid = 1'b0;
        @(posedge clk);
        #1;
        known = 1'b1;
        access(1'b1, 1'b1, 12'h7ea, 64'h4746454443424140);
        ent(40, 8'h40);
        ent(47, 8'h47);
        access(1'b1, 1'b1, 12'h7ec, 64'h5554535251504948);
        ent(52, 8'h52);
        access(1'b1, 1'b1, 12'h7ee, 64'h6362616059585756);
        ent(59, 8'h59);
        ent(63, 8'h63);
        access(1'b0, 1'b1, 12'h7ef, 64'hffffffff_a3a2a1a0);
        ent(60, 8'ha0);
        ent(63, 8'ha3);
        ent(59, 8'h59);
        access(1'b0, 1'b1, 12'h7eb, 64'h12345678_c7c6c5c4);
        ent(44, 8'hc4);
        access(1'b1, 1'b1, 12'h7e8, 64'h3938373635343332);
        ent(32, 8'h32);
        for (int f = 0; f < 2; f++) begin
            for (int a = 12'h7e6; a < 12'h7f2; a++) access(1'(f), 1'b0, 12'(a), 64'h0);
        end
        repeat (120) begin
            access(1'($urandom), 1'($urandom), 12'h7e6 + 12'($urandom % 12), {$urandom, $urandom});
        end
        access(1'b1, 1'b1, 12'h7ea, 64'h4746454443424140);
        x64 = 1'b1;
        we = 1'b0;
        addr = 12'h7ea;
        valid = 1'b1;
        @(posedge clk);
        #1;
        valid = 1'b0;
        nrst = 1'b0;
        @(posedge clk);
        #1;
        chk("reset rvalid", 256'(0), 256'(rvalid));
        chk("reset rdata", 256'(0), 256'(rdata));
        nrst = 1'b1;
        access(1'b1, 1'b0, 12'h7ea, 64'h0);
        final_report();
    end
endmodule : phys_mem_attr_cfg_csrs_hi_test
`default_nettype wire
